// [uart_fifo_control_dma_ready.sv]
// Notes on behaviour
// R1 - A zero in the enable bit turns both fifos off and a one turns both on.
// R2 - Other control fields are only taken by a write that also sets the enable bit.
// R3 - Writing the transmit clear bit empties the transmit fifo and its count, then reads zero.
// R4 - Writing the receive clear bit empties the receive fifo and its count, then reads zero.
// R5 - The mode bit picks single-transfer signalling at zero and block signalling at one, the latter only while the enable bit is set.
// R6 - The receive threshold field picks 8, 16, 24 or 28 bytes.
// R7 - The receive interrupt fires when the receive count equals the threshold; filling continues.
// R8 - The transmit threshold field picks 16, 8, 24 or 30 bytes.
// R9 - The transmit interrupt fires when the transmit count falls below its threshold.
// R10 - Outside block mode transmit-ready is low while empty and high once a byte is loaded.
// R11 - Outside block mode receive-ready is low while any byte is held and high when none is.
// R12 - In block mode transmit-ready goes high when full and low once the count falls below the threshold.
// R13 - In block mode receive-ready falls on threshold or time-out and rises only when empty.
// R14 - Reset clears every control setting, leaving the transmit threshold at 16.
// R15 - Each fifo holds 32 bytes and the time-out arrives as an input.
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_control_dma_ready #(
	parameter int FIFO_DEPTH = uart_fifo_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [uart_fifo_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [uart_fifo_pkg::DATA_W-1:0] writedata,
	output logic [uart_fifo_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	input wire logic tx_load,
	output logic [uart_fifo_pkg::BYTE_W-1:0] tx_byte,
	output logic tx_byte_valid,
	input wire logic rx_push,
	input wire logic [uart_fifo_pkg::BYTE_W-1:0] rx_byte,
	input wire logic rx_timeout,
	output logic tx_ready_n,
	output logic rx_ready_n,
	output logic irq
);
	uart_fifo_pkg::top_state_t q;
	uart_fifo_pkg::top_state_t d;
	uart_fifo_pkg::fifo_control_t wr_ctl;
	uart_fifo_pkg::irq_events_t events;
	logic [uart_fifo_pkg::IDX_W-1:0] idx;
	logic req_seen;
	logic acc;
	logic ctl_wr;
	logic tx_clear;
	logic rx_clear;
	logic tx_push;
	logic rx_pop;
	logic tx_pop;
	logic irq_clear_wr;
	logic irq_mask_wr;
	logic block_mode;
	logic [uart_fifo_pkg::CNT_W-1:0] fifo_limit;
	logic [uart_fifo_pkg::CNT_W-1:0] rx_thr;
	logic [uart_fifo_pkg::CNT_W-1:0] tx_thr;
	logic [uart_fifo_pkg::CNT_W-1:0] tx_count;
	logic [uart_fifo_pkg::CNT_W-1:0] rx_count;
	logic [uart_fifo_pkg::BYTE_W-1:0] tx_head;
	logic [uart_fifo_pkg::BYTE_W-1:0] rx_head;
	logic tx_full;
	logic tx_empty;
	logic rx_full;
	logic rx_empty;
	logic [uart_fifo_pkg::IRQ_W-1:0] irq_stat;
	logic [uart_fifo_pkg::IRQ_W-1:0] irq_mask;

	localparam logic [uart_fifo_pkg::CNT_W-1:0] DEPTH_CNT = uart_fifo_pkg::CNT_W'(FIFO_DEPTH);

	assign readdata = q.readdata;
	assign waitrequest = q.waitreq;
	assign tx_byte = q.tx_byte;
	assign tx_byte_valid = q.tx_byte_valid;
	assign tx_ready_n = q.tx_ready_n;
	assign rx_ready_n = q.rx_ready_n;

	// Bus handshake and decode
	assign idx = address[uart_fifo_pkg::IDX_LSB +: uart_fifo_pkg::IDX_W];
	assign req_seen = (read || write) && q.waitreq;
	assign acc = (read || write) && !q.waitreq;
	assign wr_ctl = writedata[uart_fifo_pkg::BYTE_W-1:0];
	assign ctl_wr = acc && write && (idx == uart_fifo_pkg::REG_FIFO_CONTROL);
	assign tx_push = acc && write && (idx == uart_fifo_pkg::REG_DATA);
	assign rx_pop = acc && read && (idx == uart_fifo_pkg::REG_DATA);
	assign irq_clear_wr = acc && write && (idx == uart_fifo_pkg::REG_IRQ_STATUS);
	assign irq_mask_wr = acc && write && (idx == uart_fifo_pkg::REG_IRQ_MASK);
	assign tx_clear = ctl_wr && wr_ctl.enable && wr_ctl.tx_fifo_clear; // R2 R3
	assign rx_clear = ctl_wr && wr_ctl.enable && wr_ctl.rx_fifo_clear; // R2 R4
	assign tx_pop = tx_load && !tx_empty;

	// Fifo off means a single holding byte
	assign fifo_limit = q.fifo_control.enable ? DEPTH_CNT : uart_fifo_pkg::LIMIT_SINGLE; // R1
	assign block_mode = q.fifo_control.enable && q.fifo_control.dma_mode; // R5
	assign rx_thr = q.fifo_control.enable ?
		uart_fifo_pkg::rx_threshold(q.fifo_control.rx_thr) : uart_fifo_pkg::LIMIT_SINGLE; // R6
	assign tx_thr = q.fifo_control.enable ?
		uart_fifo_pkg::tx_threshold(q.fifo_control.tx_thr) : uart_fifo_pkg::LIMIT_SINGLE; // R8

	byte_fifo #(
		.WIDTH(uart_fifo_pkg::BYTE_W),
		.DEPTH(FIFO_DEPTH),
		.CNT_W(uart_fifo_pkg::CNT_W)
	) u_tx_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.clear(tx_clear),
		.limit(fifo_limit),
		.push(tx_push),
		.wdata(writedata[uart_fifo_pkg::BYTE_W-1:0]),
		.pop(tx_pop),
		.rdata(tx_head),
		.count(tx_count),
		.full(tx_full),
		.empty(tx_empty)
	); // R15

	byte_fifo #(
		.WIDTH(uart_fifo_pkg::BYTE_W),
		.DEPTH(FIFO_DEPTH),
		.CNT_W(uart_fifo_pkg::CNT_W)
	) u_rx_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.clear(rx_clear),
		.limit(fifo_limit),
		.push(rx_push),
		.wdata(rx_byte),
		.pop(rx_pop),
		.rdata(rx_head),
		.count(rx_count),
		.full(rx_full),
		.empty(rx_empty)
	); // R15

	// Interrupt events
	always_comb begin
		events.rx_level = (rx_count == rx_thr) && (q.rx_cnt != rx_thr); // R7
		events.tx_below = (tx_count < tx_thr) && (q.tx_cnt >= tx_thr); // R9
		events.rx_timeout = rx_timeout; // R15
	end

	irq_status_regs #(
		.W(uart_fifo_pkg::IRQ_W)
	) u_irq (
		.clk(clk),
		.reset_n(reset_n),
		.events(events),
		.clear_wr(irq_clear_wr),
		.clear_bits(writedata[uart_fifo_pkg::IRQ_W-1:0]),
		.mask_wr(irq_mask_wr),
		.mask_wdata(writedata[uart_fifo_pkg::IRQ_W-1:0]),
		.status(irq_stat),
		.mask(irq_mask),
		.irq(irq)
	);

	always_comb begin
		d = q;
		d.waitreq = !req_seen;
		d.tx_cnt = tx_count;
		d.rx_cnt = rx_count;
		d.tx_byte_valid = tx_pop;
		if (tx_pop) begin
			d.tx_byte = tx_head;
		end
		if (req_seen && read) begin
			if (idx == uart_fifo_pkg::REG_DATA) begin
				d.readdata = rx_empty ? '0 : uart_fifo_pkg::DATA_W'(rx_head);
			end else if (idx == uart_fifo_pkg::REG_STATUS) begin
				d.readdata = '0;
				d.readdata[uart_fifo_pkg::STAT_ENABLE] = q.fifo_control.enable;
				d.readdata[uart_fifo_pkg::STAT_DMA_MODE] = q.fifo_control.dma_mode;
				d.readdata[uart_fifo_pkg::STAT_TX_CNT_LSB +: uart_fifo_pkg::CNT_W] = tx_count;
				d.readdata[uart_fifo_pkg::STAT_RX_CNT_LSB +: uart_fifo_pkg::CNT_W] = rx_count;
			end else if (idx == uart_fifo_pkg::REG_IRQ_STATUS) begin
				d.readdata = uart_fifo_pkg::DATA_W'(irq_stat);
			end else if (idx == uart_fifo_pkg::REG_IRQ_MASK) begin
				d.readdata = uart_fifo_pkg::DATA_W'(irq_mask);
			end else begin
				d.readdata = '0;
			end
		end
		if (ctl_wr) begin
			if (wr_ctl.enable) begin
				d.fifo_control = wr_ctl; // R2
				d.fifo_control.tx_fifo_clear = 1'b0; // R3
				d.fifo_control.rx_fifo_clear = 1'b0; // R4
			end else begin
				d.fifo_control.enable = 1'b0; // R1 R2
			end
		end
		if (block_mode) begin
			if (tx_count == DEPTH_CNT) begin
				d.tx_ready_n = 1'b1; // R12
			end else if (tx_count < tx_thr) begin
				d.tx_ready_n = 1'b0; // R12
			end
			if (rx_count == uart_fifo_pkg::CNT_ZERO) begin
				d.rx_ready_n = 1'b1; // R13
			end else if ((rx_count >= rx_thr) || rx_timeout) begin
				d.rx_ready_n = 1'b0; // R13
			end
		end else begin
			d.tx_ready_n = (tx_count != uart_fifo_pkg::CNT_ZERO); // R10
			d.rx_ready_n = (rx_count == uart_fifo_pkg::CNT_ZERO); // R11
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= uart_fifo_pkg::TOP_RESET; // R14
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_enable_write;
		ctl_wr |=> (q.fifo_control.enable == $past(wr_ctl.enable));
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable bit not taken"); // R1

	property p_ignore_fields;
		ctl_wr && !wr_ctl.enable |=> $stable(q.fifo_control.rx_thr)
			&& $stable(q.fifo_control.tx_thr) && $stable(q.fifo_control.dma_mode);
	endproperty
	a_ignore_fields: assert property (p_ignore_fields) else $error("fields changed while off"); // R2

	property p_tx_clear;
		tx_clear |=> (tx_count == uart_fifo_pkg::CNT_ZERO) && !q.fifo_control.tx_fifo_clear;
	endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("tx fifo not cleared"); // R3

	property p_rx_clear;
		rx_clear |=> (rx_count == uart_fifo_pkg::CNT_ZERO) && !q.fifo_control.rx_fifo_clear;
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("rx fifo not cleared"); // R4

	property p_rx_level_irq;
		q.fifo_control.enable && (rx_count == rx_thr) && (q.rx_cnt != rx_thr)
			|=> irq_stat[0];
	endproperty
	a_rx_level_irq: assert property (p_rx_level_irq) else $error("rx level irq missing"); // R7

	property p_tx_below_irq;
		(tx_count < tx_thr) && (q.tx_cnt >= tx_thr) |=> irq_stat[1];
	endproperty
	a_tx_below_irq: assert property (p_tx_below_irq) else $error("tx below irq missing"); // R9

	property p_single_ready;
		!block_mode ##1 !block_mode |-> (tx_ready_n == ($past(tx_count) != '0))
			&& (rx_ready_n == ($past(rx_count) == '0));
	endproperty
	a_single_ready: assert property (p_single_ready) else $error("single mode ready wrong"); // R10 R11

	property p_block_tx_full;
		block_mode && (tx_count == DEPTH_CNT) |=> tx_ready_n;
	endproperty
	a_block_tx_full: assert property (p_block_tx_full) else $error("tx ready not high at full"); // R12

	property p_block_rx_hold;
		block_mode && rx_timeout && (rx_count != '0) |=> !rx_ready_n;
	endproperty
	a_block_rx_hold: assert property (p_block_rx_hold) else $error("rx ready not low"); // R13

	property p_block_tx_low;
		block_mode && (tx_count < tx_thr) |=> !tx_ready_n;
	endproperty
	a_block_tx_low: assert property (p_block_tx_low) else $error("tx ready not low"); // R12

	property p_block_rx_empty;
		block_mode && (rx_count == uart_fifo_pkg::CNT_ZERO) |=> rx_ready_n;
	endproperty
	a_block_rx_empty: assert property (p_block_rx_empty) else $error("rx ready not high"); // R13

	property p_rx_accept;
		q.fifo_control.enable && rx_push && !rx_full && !rx_clear && !rx_pop
			|=> (rx_count == $past(rx_count) + uart_fifo_pkg::CNT_W'(1));
	endproperty
	a_rx_accept: assert property (p_rx_accept) else $error("rx byte not taken"); // R7

	property p_timeout_irq;
		rx_timeout |=> irq_stat[2];
	endproperty
	a_timeout_irq: assert property (p_timeout_irq) else $error("timeout irq missing"); // R15

	property p_reset_state;
		$rose(reset_n) |-> (q.fifo_control == uart_fifo_pkg::FIFO_CONTROL_RESET);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("control not cleared"); // R14

	property p_depth;
		(tx_count <= DEPTH_CNT) && (rx_count <= DEPTH_CNT);
	endproperty
	a_depth: assert property (p_depth) else $error("fifo count beyond depth"); // R15

	c_block_rx: cover property (block_mode ##1 $fell(rx_ready_n));
	c_tx_clear: cover property (tx_clear && (tx_count != '0));
	c_irq: cover property ($rose(irq));
	c_rx_full: cover property (q.fifo_control.enable && rx_full);
	c_tx_full: cover property (block_mode && tx_full);
endmodule : uart_fifo_control_dma_ready
`default_nettype wire

// [uart_fifo_pkg.sv]
`default_nettype none
package uart_fifo_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 5;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 3;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int CNT_W = 6;
	localparam int IRQ_W = 3;

	// Register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] REG_DATA = 3'h0;
	localparam logic [IDX_W-1:0] REG_FIFO_CONTROL = 3'h1;
	localparam logic [IDX_W-1:0] REG_STATUS = 3'h2;
	localparam logic [IDX_W-1:0] REG_IRQ_STATUS = 3'h3;
	localparam logic [IDX_W-1:0] REG_IRQ_MASK = 3'h4;

	// Status register field positions
	localparam int STAT_ENABLE = 0;
	localparam int STAT_DMA_MODE = 1;
	localparam int STAT_TX_CNT_LSB = 8;
	localparam int STAT_RX_CNT_LSB = 16;

	// Fifo limits and thresholds
	localparam logic [CNT_W-1:0] LIMIT_FULL = 6'h20;
	localparam logic [CNT_W-1:0] LIMIT_SINGLE = 6'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] RX_THR_0 = 6'h08;
	localparam logic [CNT_W-1:0] RX_THR_1 = 6'h10;
	localparam logic [CNT_W-1:0] RX_THR_2 = 6'h18;
	localparam logic [CNT_W-1:0] RX_THR_3 = 6'h1C;
	localparam logic [CNT_W-1:0] TX_THR_0 = 6'h10;
	localparam logic [CNT_W-1:0] TX_THR_1 = 6'h08;
	localparam logic [CNT_W-1:0] TX_THR_2 = 6'h18;
	localparam logic [CNT_W-1:0] TX_THR_3 = 6'h1E;

	// Layout matches the written control byte
	typedef struct packed {
		logic [1:0] rx_thr;
		logic [1:0] tx_thr;
		logic dma_mode;
		logic tx_fifo_clear;
		logic rx_fifo_clear;
		logic enable;
	} fifo_control_t;

	localparam fifo_control_t FIFO_CONTROL_RESET = 8'h00;

	typedef struct packed {
		logic rx_timeout;
		logic tx_below;
		logic rx_level;
	} irq_events_t;

	typedef struct packed {
		fifo_control_t fifo_control;
		logic waitreq;
		logic [DATA_W-1:0] readdata;
		logic [BYTE_W-1:0] tx_byte;
		logic tx_byte_valid;
		logic tx_ready_n;
		logic rx_ready_n;
		logic [CNT_W-1:0] tx_cnt;
		logic [CNT_W-1:0] rx_cnt;
	} top_state_t;

	localparam top_state_t TOP_RESET = '{
		fifo_control: FIFO_CONTROL_RESET,
		waitreq: 1'b1,
		readdata: 32'h0000_0000,
		tx_byte: 8'h00,
		tx_byte_valid: 1'b0,
		tx_ready_n: 1'b0,
		rx_ready_n: 1'b1,
		tx_cnt: 6'h00,
		rx_cnt: 6'h00
	};

	function automatic logic [CNT_W-1:0] rx_threshold(input logic [1:0] sel);
		case (sel)
			2'h0: rx_threshold = RX_THR_0;
			2'h1: rx_threshold = RX_THR_1;
			2'h2: rx_threshold = RX_THR_2;
			default: rx_threshold = RX_THR_3;
		endcase
	endfunction : rx_threshold

	function automatic logic [CNT_W-1:0] tx_threshold(input logic [1:0] sel);
		case (sel)
			2'h0: tx_threshold = TX_THR_0;
			2'h1: tx_threshold = TX_THR_1;
			2'h2: tx_threshold = TX_THR_2;
			default: tx_threshold = TX_THR_3;
		endcase
	endfunction : tx_threshold
endpackage : uart_fifo_pkg
`default_nettype wire

// [byte_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int CNT_W = 6
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic [CNT_W-1:0] limit,
	input wire logic push,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic pop,
	output logic [WIDTH-1:0] rdata,
	output logic [CNT_W-1:0] count,
	output logic full,
	output logic empty
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(DEPTH);

	typedef struct packed {
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [CNT_W-1:0] count;
	} fifo_state_t;

	fifo_state_t q;
	fifo_state_t d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic do_push;
	logic do_pop;

	assign count = q.count;
	assign empty = (q.count == '0);
	assign full = (q.count >= limit) || (q.count == DEPTH_CNT);
	assign rdata = mem[q.rd_ptr];
	assign do_push = push && !full && !clear;
	assign do_pop = pop && !empty && !clear;

	always_comb begin
		d = q;
		if (clear) begin
			d = '0;
		end else begin
			if (do_push) begin
				d.wr_ptr = q.wr_ptr + PTR_W'(1);
			end
			if (do_pop) begin
				d.rd_ptr = q.rd_ptr + PTR_W'(1);
			end
			if (do_push && !do_pop) begin
				d.count = q.count + CNT_W'(1);
			end else if (do_pop && !do_push) begin
				d.count = q.count - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[q.wr_ptr] <= wdata;
		end
	end
endmodule : byte_fifo
`default_nettype wire

// [irq_status_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_status_regs #(
	parameter int W = 3
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [W-1:0] events,
	input wire logic clear_wr,
	input wire logic [W-1:0] clear_bits,
	input wire logic mask_wr,
	input wire logic [W-1:0] mask_wdata,
	output logic [W-1:0] status,
	output logic [W-1:0] mask,
	output logic irq
);
	typedef struct packed {
		logic [W-1:0] status;
		logic [W-1:0] mask;
		logic irq;
	} irq_state_t;

	irq_state_t q;
	irq_state_t d;

	assign status = q.status;
	assign mask = q.mask;
	assign irq = q.irq;

	always_comb begin
		d = q;
		// Set wins over a clear in the same cycle
		d.status = (q.status & ~(clear_wr ? clear_bits : '0)) | events;
		if (mask_wr) begin
			d.mask = mask_wdata;
		end
		d.irq = |(d.status & d.mask);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : irq_status_regs
`default_nettype wire

// [serial_side_model.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_side_model (
	input wire logic clk,
	input wire logic [7:0] tx_byte,
	input wire logic tx_byte_valid,
	output logic tx_load,
	output logic rx_push,
	output logic [7:0] rx_byte,
	output logic rx_timeout
);
	initial begin
		tx_load = 1'b0;
		rx_push = 1'b0;
		rx_byte = 8'h00;
		rx_timeout = 1'b0;
	end
	task automatic push(input logic [7:0] b);
		@(posedge clk);
		rx_push <= 1'b1;
		rx_byte <= b;
		@(posedge clk);
		rx_push <= 1'b0;
		rx_byte <= ~b; // Stale data never repeats
	endtask : push
	task automatic pop(output logic v, output logic [7:0] b);
		@(posedge clk);
		tx_load <= 1'b1;
		@(posedge clk);
		tx_load <= 1'b0;
		@(posedge clk);
		v = tx_byte_valid;
		b = tx_byte;
	endtask : pop
	task automatic timeout();
		@(posedge clk);
		rx_timeout <= 1'b1;
		@(posedge clk);
		rx_timeout <= 1'b0;
	endtask : timeout
endmodule : serial_side_model
`default_nettype wire

// [uart_fifo_control_dma_ready_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_control_dma_ready_tb;
	logic clk, reset_n, read, write, tx_load, rx_push, rx_timeout, waitrequest;
	logic tx_byte_valid, tx_ready_n, rx_ready_n, irq, v;
	logic [uart_fifo_pkg::ADDR_W-1:0] address;
	logic [31:0] writedata, readdata, d;
	logic [7:0] tx_byte, rx_byte, b;
	logic [7:0] rxq[$], txq[$];
	int num_checks, fails, s, i, rt, tt;
	int rx_thr_t[4] = '{8, 16, 24, 28};
	int tx_thr_t[4] = '{16, 8, 24, 30};
	uart_fifo_control_dma_ready dut (.clk(clk), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .tx_load(tx_load), .tx_byte(tx_byte),
		.tx_byte_valid(tx_byte_valid), .rx_push(rx_push), .rx_byte(rx_byte),
		.rx_timeout(rx_timeout), .tx_ready_n(tx_ready_n), .rx_ready_n(rx_ready_n), .irq(irq));
	serial_side_model m (.clk(clk), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
		.tx_load(tx_load), .rx_push(rx_push), .rx_byte(rx_byte), .rx_timeout(rx_timeout));
	function automatic logic [31:0] ctl(int r, int t, int md, int tc, int rc, int e);
		ctl = {24'h0, 2'(r), 2'(t), 1'(md), 1'(tc), 1'(rc), 1'(e)};
	endfunction : ctl
	function automatic logic [31:0] st(int e, int md, int t, int r);
		st = {10'h0, 6'(r), 2'h0, 6'(t), 6'h0, 1'(md), 1'(e)};
	endfunction : st
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [2:0] idx, input logic [31:0] wd);
		int k;
		@(posedge clk);
		address <= {idx, 2'h0};
		write <= w;
		read <= !w;
		writedata <= wd;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) break;
		end
		d = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (k == 20) begin
			chk("waitrequest", 0, 1);
			test_done();
		end
	endtask : bus
	task automatic idle(int n);
		repeat (n) @(posedge clk);
	endtask : idle
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		reset_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = '0;
		writedata = '0;
		num_checks = 0;
		fails = 0;
		d = $urandom(59851);
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		idle(1);
		chk("tx_ready_n", 0, tx_ready_n);
		chk("rx_ready_n", 1, rx_ready_n);
		bus(0, uart_fifo_pkg::REG_STATUS, 0);
		chk("status", 0, d);
		bus(0, uart_fifo_pkg::REG_FIFO_CONTROL, 0);
		chk("control", 0, d);
		bus(0, 3'h7, 0);
		chk("unmapped", 0, d);
		$display("test reset done");
		bus(1, uart_fifo_pkg::REG_DATA, 32'hA5);
		bus(1, uart_fifo_pkg::REG_DATA, 32'h5A);
		idle(2);
		chk("tx_ready_n", 1, tx_ready_n);
		bus(1, uart_fifo_pkg::REG_FIFO_CONTROL, ctl(3, 3, 1, 0, 0, 0));
		bus(0, uart_fifo_pkg::REG_STATUS, 0);
		chk("status", st(0, 0, 1, 0), d);
		m.pop(v, b);
		chk("tx valid", 1, v);
		chk("tx byte", 8'hA5, b);
		idle(2);
		chk("tx_ready_n", 0, tx_ready_n);
		m.push(8'h3C);
		idle(2);
		chk("rx_ready_n", 0, rx_ready_n);
		bus(0, uart_fifo_pkg::REG_DATA, 0);
		chk("rx data", 8'h3C, d);
		idle(3);
		chk("rx_ready_n", 1, rx_ready_n);
		$display("test fifo off done");
		for (s = 0; s < 4; s++) begin
			rt = rx_thr_t[s];
			tt = tx_thr_t[s];
			txq.delete();
			rxq.delete();
			bus(1, uart_fifo_pkg::REG_FIFO_CONTROL, ctl(s, s, 1, 1, 1, 1));
			bus(1, uart_fifo_pkg::REG_IRQ_STATUS, 7);
			bus(0, uart_fifo_pkg::REG_STATUS, 0);
			chk("status", st(1, 1, 0, 0), d);
			for (i = 0; i < 40; i++) begin
				b = 8'($urandom);
				if (i < 32) rxq.push_back(b);
				m.push(b);
				if (i == rt - 2 || i == rt - 1) begin
					idle(3);
					bus(0, uart_fifo_pkg::REG_IRQ_STATUS, 0);
					chk("rx level irq", 32'(i == rt - 1), 32'(d[0]));
					chk("rx_ready_n", 32'(i != rt - 1), rx_ready_n);
				end
			end
			bus(0, uart_fifo_pkg::REG_STATUS, 0);
			chk("status", st(1, 1, 0, 32), d);
			bus(0, uart_fifo_pkg::REG_DATA, 0);
			chk("rx data", rxq[0], d);
			bus(1, uart_fifo_pkg::REG_FIFO_CONTROL, ctl(s, s, 1, 0, 1, 1));
			bus(0, uart_fifo_pkg::REG_STATUS, 0);
			chk("status", st(1, 1, 0, 0), d);
			chk("rx_ready_n", 1, rx_ready_n);
			m.push(8'($urandom));
			idle(3);
			chk("rx_ready_n", 1, rx_ready_n);
			m.timeout();
			idle(3);
			chk("rx_ready_n", 0, rx_ready_n);
			bus(0, uart_fifo_pkg::REG_IRQ_STATUS, 0);
			chk("timeout irq", 1, 32'(d[2]));
			bus(0, uart_fifo_pkg::REG_DATA, 0);
			idle(3);
			chk("rx_ready_n", 1, rx_ready_n);
			for (i = 0; i < 33; i++) begin
				b = 8'($urandom);
				if (i < 32) txq.push_back(b);
				bus(1, uart_fifo_pkg::REG_DATA, 32'(b));
			end
			idle(2);
			chk("tx_ready_n", 1, tx_ready_n);
			bus(1, uart_fifo_pkg::REG_IRQ_STATUS, 7);
			for (i = 32; i >= tt; i--) begin
				m.pop(v, b);
				chk("tx byte", txq.pop_front(), b);
				if (i <= tt + 1) begin
					idle(3);
					bus(0, uart_fifo_pkg::REG_IRQ_STATUS, 0);
					chk("tx below irq", 32'(i == tt), 32'(d[1]));
					chk("tx_ready_n", 32'(i != tt), tx_ready_n);
				end
			end
			if (s == 0) begin
				chk("irq masked", 0, irq);
				bus(1, uart_fifo_pkg::REG_IRQ_MASK, 2);
				idle(2);
				chk("irq", 1, irq);
				bus(0, uart_fifo_pkg::REG_IRQ_MASK, 0);
				chk("irq mask", 2, d);
				bus(1, uart_fifo_pkg::REG_IRQ_STATUS, 2);
				idle(2);
				chk("irq cleared", 0, irq);
			end
			$display("test threshold %0d done", s);
		end
		bus(1, uart_fifo_pkg::REG_FIFO_CONTROL, ctl(0, 0, 0, 0, 0, 1));
		idle(2);
		chk("tx_ready_n", 1, tx_ready_n);
		bus(1, uart_fifo_pkg::REG_FIFO_CONTROL, ctl(0, 0, 0, 1, 0, 1));
		idle(3);
		chk("tx_ready_n", 0, tx_ready_n);
		m.push(8'h81);
		idle(2);
		chk("rx_ready_n", 0, rx_ready_n);
		$display("test mode 0 done");
		test_done();
	end
endmodule : uart_fifo_control_dma_ready_tb
`default_nettype wire
